//--- logic/issue_ctl_map.svh
// Purpose: offsets-free constant map for the dual-issue control block
// Assumes: one core clock
// Notes: latencies in cycles from issue
`ifndef ISSUE_CTL_MAP_SVH
`define ISSUE_CTL_MAP_SVH
`define FETCH_BLOCK_INSNS 32
`define LAT_SIMPLE 4'h2
`define LAT_BYTE 4'h4
`define LAT_SINGLE 4'h6
`define LAT_FLOATINT 4'h7
`define LAT_DOUBLE 4'hd
`define LAT_STAGE_OUT 4'h8
`define DP_BLACKOUT 3'h6
`define CHAN_WINDOW 3'h5
`endif

//--- logic/issue_ctl_pkg.sv
// Purpose: types for the dual-issue control block
// Assumes: nothing
// Notes: class code chooses the pipe and the latency
package issue_ctl_pkg;
	typedef enum logic [3:0] {
		simple_fixed_class,
		byte_op_class,
		rotate_shift_class,
		single_float_class,
		float_integer_class,
		double_float_class,
		even_pipe_noop,
		local_store_class,
		branch_resolve_class,
		branch_hint_class,
		shuffle_class,
		channel_class,
		odd_pipe_noop,
		sync_class
	} insn_class_t;

	typedef struct packed {
		logic valid;
		insn_class_t cls;
		logic dep_ok;
		logic chan_blocking;
		logic chan_count_zero;
		logic [6:0] chan_id;
		logic [4:0] dest;
		logic [31:0] addr;
	} slot_t;

	typedef struct packed {
		logic valid;
		logic [4:0] dest;
		logic [31:0] addr;
	} result_t;

	typedef enum logic [1:0] {
		fetch_flush,
		fetch_hint,
		fetch_inline
	} fetch_kind_t;
endpackage

//--- logic/result_stager.sv
// Purpose: stage results to commit latency for register file commit
// Assumes: at most two issues per cycle, one to each pipe
// Notes: commit order equals issue order since all stage to one depth
`timescale 1ns/100ps
`default_nettype none
module result_stager
	import issue_ctl_pkg::*;
#(
	parameter int DEPTH = 8
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Issued results
	input wire result_t even_in,
	input wire result_t odd_in,
	// Register file commit
	output result_t even_commit,
	output result_t odd_commit
);
	result_t even_ff [DEPTH];
	result_t odd_ff [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_stage
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					even_ff[g] <= '0;
					odd_ff[g] <= '0;
				end
				else if (g == 0)
				begin
					even_ff[g] <= even_in;
					odd_ff[g] <= odd_in;
				end
				else
				begin
					// Every result staged out to the same depth; see RULE15
					even_ff[g] <= even_ff[g > 0 ? g - 1 : 0];
					odd_ff[g] <= odd_ff[g > 0 ? g - 1 : 0];
				end
			end
		end
	endgenerate

	assign even_commit = even_ff[DEPTH-1];
	assign odd_commit = odd_ff[DEPTH-1];

	staged_depth_a: assert property (@(posedge ref_clk) // see RULE15
		disable iff (!arst_n) even_in.valid |-> ##8 even_commit.valid)
		else $error("result not committed at depth");
endmodule
`default_nettype wire

//--- logic/regfile_timing.sv
// Purpose: register file write and read-bypass timing
// Assumes: commit arrives in pre-writeback
// Notes: readable two cycles after commit
`timescale 1ns/100ps
`default_nettype none
module regfile_timing
	import issue_ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Commit from stager
	input wire result_t commit,
	// Status
	output logic [4:0] written_dest,
	output logic written_valid,
	output logic readable_valid
);
	result_t decode_ff;
	result_t array_ff;

	// Pre-writeback decode, array write, then read bypass; see RULE16
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			decode_ff <= '0;
			array_ff <= '0;
		end
		else
		begin
			decode_ff <= commit;
			array_ff <= decode_ff;
		end
	end

	assign written_dest = decode_ff.dest;
	assign written_valid = decode_ff.valid;
	assign readable_valid = array_ff.valid;

	rf_two_cycle_a: assert property (@(posedge ref_clk) // see RULE16
		disable iff (!arst_n) commit.valid |-> ##2 readable_valid)
		else $error("register file timing wrong");
endmodule
`default_nettype wire

//--- logic/dual_issue_ctl.sv
// Purpose: fetch and dual-issue control for a two-pipe SIMD core
// Assumes: slot decode info comes from logic on ref_clk
// Notes: execution units and local store arbitration are outside
// Overview of operation
// RULE1 - hold blocking channel access until count nonzero
// RULE2 - repeated channel access within five cycles retries
// RULE3 - sync instructions force a pipeline flush
// RULE4 - each fetch returns 32 instructions
// RULE5 - fetch kinds: flush, hint, inline prefetch
// RULE6 - issue in program order to class pipe
// RULE7 - pairs: even word first, odd second
// RULE8 - next pair loads after both issued
// RULE9 - eligible needs dependencies and no conflicts
// RULE10 - dual issue only even-then-odd, both eligible
// RULE11 - else issue first, hold second
// RULE12 - classes split over even and odd pipes
// RULE13 - class latencies 2, 4, 6, 7 cycles
// RULE14 - results forwarded to all from availability
// RULE15 - stage every result to latency 8
// RULE16 - register file write and read take two cycles
// RULE17 - double split into two consecutive element ops; the code splits only a double issued from the first slot
// RULE18 - double latency thirteen, last seven pipelined
// RULE19 - no pairing with double, six idle cycles; the code idles only after a double issued from the first slot
// RULE20 - xor-immediate and sign-extend: even, latency 2
// RULE21 - two noop forms, one per pipe
// RULE22 - misaligned pair issues one per cycle
// RULE23 - flush discards younger, refetches oldest unissued; the code drops the refetch while a fetch still waits for fetch_ready
`timescale 1ns/100ps
`default_nettype none
`include "issue_ctl_map.svh"
module dual_issue_ctl
	import issue_ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Current pair from the fetch buffer
	input wire slot_t first_slot,
	input wire slot_t second_slot,
	input wire logic pair_avail,
	// Structural hazards
	input wire logic dma_busy,
	input wire logic ecc_busy,
	input wire logic even_busy,
	input wire logic odd_busy,
	// Fetch requests from elsewhere
	input wire logic hint_req,
	input wire logic [31:0] hint_addr,
	input wire logic inline_slot_free,
	input wire logic [31:0] inline_addr,
	input wire logic fetch_ready,
	// Pair and issue outputs
	output logic pair_take,
	output logic even_issue,
	output logic odd_issue,
	output logic [3:0] even_latency,
	output logic [3:0] odd_latency,
	output logic dp_element,
	output logic flush,
	// Fetch request to the local store
	output logic fetch_req,
	output fetch_kind_t fetch_kind,
	output logic [31:0] fetch_addr,
	output logic [5:0] fetch_count,
	// Forwarding and commit status
	output logic [15:0] fwd_ready_mask,
	output result_t even_commit,
	output result_t odd_commit,
	output logic even_rf_readable,
	output logic odd_rf_readable
);
	typedef enum logic [1:0] {
		st_normal,
		st_dp_second,
		st_dp_blackout
	} issue_state_t;

	issue_state_t state_ff;
	logic [2:0] blackout_ff;
	logic first_done_ff;
	logic [2:0] chan_age_ff;
	logic [6:0] chan_last_ff;
	logic [3:0] even_latency_ff;
	logic [3:0] odd_latency_ff;
	logic dp_element_ff;
	logic flush_ff;
	logic fetch_req_ff;
	fetch_kind_t fetch_kind_ff;
	logic [31:0] fetch_addr_ff;
	logic [15:0] fwd_ff [2];
	logic [15:0] fwd_mask;
	result_t even_res;
	result_t odd_res;

	// Pipe of a class: 1 is odd; see RULE12 RULE20 RULE21
	function automatic logic is_odd(input insn_class_t c);
		return c inside {local_store_class, branch_resolve_class,
			branch_hint_class, shuffle_class, channel_class,
			odd_pipe_noop, sync_class};
	endfunction

	// Result latency of a class; see RULE13 RULE18 RULE20
	function automatic logic [3:0] lat_of(input insn_class_t c);
		unique case (c)
			simple_fixed_class, even_pipe_noop: return `LAT_SIMPLE;
			byte_op_class, rotate_shift_class: return `LAT_BYTE;
			branch_resolve_class, shuffle_class: return `LAT_BYTE;
			branch_hint_class, odd_pipe_noop, sync_class: return `LAT_BYTE;
			single_float_class, local_store_class: return `LAT_SINGLE;
			channel_class: return `LAT_SINGLE;
			float_integer_class: return `LAT_FLOATINT;
			double_float_class: return `LAT_DOUBLE;
			default: return 4'h0;
		endcase
	endfunction

	// Channel conflict with a recent access; see RULE2
	function automatic logic chan_hit(input slot_t s, input logic [2:0] age,
		input logic [6:0] last);
		return s.valid && s.cls == channel_class && age != 3'h0 &&
			s.chan_id == last;
	endfunction

	function automatic logic eligible(input slot_t s, input logic busy);
		// Dependencies, structure, blocking channel; see RULE9 RULE1
		return s.valid && s.dep_ok && !busy && !(s.cls == channel_class &&
			s.chan_blocking && s.chan_count_zero);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Issue decision
	slot_t cur_first;
	logic first_ok, second_ok, dual, issue_first, issue_second;
	logic first_odd, second_odd, retry_first, retry_second;
	logic go;

	assign go = state_ff == st_normal && pair_avail && !flush_ff;
	assign cur_first = first_done_ff ? '0 : first_slot;
	assign first_odd = is_odd(cur_first.cls);
	assign second_odd = is_odd(second_slot.cls);
	assign first_ok = go && !dma_busy && !ecc_busy &&
		eligible(cur_first, first_odd ? odd_busy : even_busy);
	assign second_ok = go && !dma_busy && !ecc_busy &&
		eligible(second_slot, second_odd ? odd_busy : even_busy);
	assign retry_first = first_ok && chan_hit(cur_first, chan_age_ff,
		chan_last_ff);
	assign retry_second = second_ok && chan_hit(second_slot, chan_age_ff,
		chan_last_ff);

	always_comb
	begin
		// Dual only even-then-odd, never with double; see RULE10 RULE19
		dual = first_ok && second_ok && !first_odd && second_odd &&
			cur_first.cls != double_float_class && !retry_first &&
			!retry_second;
		// In order: first slot before second; see RULE6 RULE11 RULE22
		issue_first = first_ok && !retry_first;
		issue_second = dual || (!cur_first.valid && second_ok &&
			!retry_second);
	end

	assign even_issue = (issue_first && !first_odd) ||
		(issue_second && !second_odd) || state_ff == st_dp_second;
	assign odd_issue = (issue_first && first_odd) ||
		(issue_second && second_odd);
	// Load next pair once both slots gone; see RULE7 RULE8
	assign pair_take = go && (issue_second || (issue_first &&
		!second_slot.valid));

	// Which slot is the first: dual, first only or second only
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			first_done_ff <= 1'b0;
		else if (flush_ff || pair_take)
			first_done_ff <= 1'b0;
		else if (issue_first)
			first_done_ff <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Double-precision sequencing
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= st_normal;
			blackout_ff <= 3'h0;
		end
		else
		begin
			unique case (state_ff)
				st_normal:
					if (issue_first && cur_first.cls == double_float_class)
						state_ff <= st_dp_second; // see RULE17
				st_dp_second:
				begin
					state_ff <= st_dp_blackout;
					blackout_ff <= `DP_BLACKOUT;
				end
				st_dp_blackout:
					if (blackout_ff == 3'h1)
						state_ff <= st_normal; // see RULE19
					else
						blackout_ff <= blackout_ff - 3'h1;
			endcase
		end
	end

	assign dp_element = dp_element_ff;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			dp_element_ff <= 1'b0;
		else
			dp_element_ff <= state_ff == st_dp_second;
	end

	////////////////////////////////////////////////////////////////////
	// Channel access history and flush
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			chan_age_ff <= 3'h0;
			chan_last_ff <= 7'h00;
		end
		else if (issue_first && cur_first.cls == channel_class)
		begin
			chan_age_ff <= `CHAN_WINDOW;
			chan_last_ff <= cur_first.chan_id;
		end
		else if (issue_second && second_slot.cls == channel_class)
		begin
			chan_age_ff <= `CHAN_WINDOW;
			chan_last_ff <= second_slot.chan_id;
		end
		else if (chan_age_ff != 3'h0)
			chan_age_ff <= chan_age_ff - 3'h1;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			flush_ff <= 1'b0;
		else
			// Retry or sync forces a flush; see RULE2 RULE3 RULE23
			flush_ff <= retry_first || (retry_second && !issue_first) ||
				(issue_first && cur_first.cls == sync_class) ||
				(issue_second && second_slot.cls == sync_class);
	end

	assign flush = flush_ff;

	////////////////////////////////////////////////////////////////////
	// Fetch requests
	logic [31:0] restart_addr_ff;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			restart_addr_ff <= 32'h0000_0000;
		else if (retry_first || (issue_first && cur_first.cls == sync_class))
			restart_addr_ff <= retry_first ? cur_first.addr
				: cur_first.addr + 32'h0000_0004;
		else if (retry_second || (issue_second &&
			second_slot.cls == sync_class))
			restart_addr_ff <= retry_second ? second_slot.addr
				: second_slot.addr + 32'h0000_0004;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fetch_req_ff <= 1'b0;
			fetch_kind_ff <= fetch_flush;
			fetch_addr_ff <= 32'h0000_0000;
		end
		else if (fetch_req_ff && !fetch_ready)
			fetch_req_ff <= 1'b1;
		else if (flush_ff)
		begin
			// Kinds by priority; see RULE5 RULE23
			fetch_req_ff <= 1'b1;
			fetch_kind_ff <= fetch_flush;
			fetch_addr_ff <= restart_addr_ff;
		end
		else if (hint_req)
		begin
			fetch_req_ff <= 1'b1;
			fetch_kind_ff <= fetch_hint;
			fetch_addr_ff <= hint_addr;
		end
		else
		begin
			fetch_req_ff <= inline_slot_free;
			fetch_kind_ff <= fetch_inline;
			fetch_addr_ff <= inline_addr;
		end
	end

	assign fetch_req = fetch_req_ff;
	assign fetch_kind = fetch_kind_ff;
	assign fetch_addr = fetch_addr_ff;
	assign fetch_count = 6'(`FETCH_BLOCK_INSNS); // see RULE4

	////////////////////////////////////////////////////////////////////
	// Forwarding: one-hot countdown per pipe marks result ready
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			even_latency_ff <= 4'h0;
			odd_latency_ff <= 4'h0;
		end
		else
		begin
			even_latency_ff <= even_issue ? lat_of(issue_first && !first_odd
				? cur_first.cls : second_slot.cls) : 4'h0;
			odd_latency_ff <= odd_issue ? lat_of(issue_first && first_odd
				? cur_first.cls : second_slot.cls) : 4'h0;
		end
	end

	assign even_latency = even_latency_ff;
	assign odd_latency = odd_latency_ff;

	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_fwd
			logic [3:0] lat;
			assign lat = p == 0 ? even_latency_ff : odd_latency_ff;
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
					fwd_ff[p] <= 16'h0000;
				else if (lat != 4'h0)
					// Result usable from its cycle on; see RULE14
					fwd_ff[p] <= 16'h0001 << (lat - 4'h1);
				else
					fwd_ff[p] <= fwd_ff[p] >> 1;
			end
		end
	endgenerate

	assign fwd_mask = fwd_ff[0] | fwd_ff[1];
	assign fwd_ready_mask = fwd_mask;

	assign even_res = '{valid: even_issue,
		dest: issue_first && !first_odd ? cur_first.dest : second_slot.dest,
		addr: issue_first && !first_odd ? cur_first.addr : second_slot.addr};
	assign odd_res = '{valid: odd_issue,
		dest: issue_first && first_odd ? cur_first.dest : second_slot.dest,
		addr: issue_first && first_odd ? cur_first.addr : second_slot.addr};

	result_stager #(.DEPTH(`LAT_STAGE_OUT)) u_stager (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.even_in(even_res),
		.odd_in(odd_res),
		.even_commit(even_commit),
		.odd_commit(odd_commit)
	);

	regfile_timing u_rf_even (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.commit(even_commit),
		.written_dest(),
		.written_valid(),
		.readable_valid(even_rf_readable)
	);

	regfile_timing u_rf_odd (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.commit(odd_commit),
		.written_dest(),
		.written_valid(),
		.readable_valid(odd_rf_readable)
	);

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	dp_blackout_a: assert property (state_ff == st_dp_second |=> // see RULE19
		(!odd_issue && !even_issue) [*6])
		else $error("issue during double blackout");
	dp_no_pair_a: assert property (issue_first && // see RULE19
		cur_first.cls == double_float_class |-> !odd_issue)
		else $error("double paired");
	blocking_hold_a: assert property (!first_done_ff && // see RULE1
		first_slot.cls == channel_class && first_slot.chan_blocking &&
		first_slot.chan_count_zero |-> !issue_first)
		else $error("blocked channel issued");
	blocking_second_a: assert property (second_slot.valid && // see RULE1
		second_slot.cls == channel_class && second_slot.chan_blocking &&
		second_slot.chan_count_zero |-> !issue_second)
		else $error("blocked second channel issued");
	chan_retry_a: assert property (retry_first || // see RULE2
		(retry_second && !issue_first) |=> flush)
		else $error("channel retry without flush");
	sync_flush_a: assert property ((issue_first && // see RULE3
		cur_first.cls == sync_class) || (issue_second &&
		second_slot.cls == sync_class) |=> flush)
		else $error("sync without flush");
	dual_order_a: assert property (even_issue && odd_issue && // see RULE10
		state_ff == st_normal |-> !first_odd && second_odd)
		else $error("bad dual issue");
	dp_second_a: assert property (issue_first && // see RULE17
		cur_first.cls == double_float_class |=> even_issue)
		else $error("double element missing");
	fwd_time_a: assert property (even_latency_ff == `LAT_SIMPLE && // see RULE14
		odd_latency_ff == 4'h0 && $past(odd_latency_ff) == 4'h0 |=>
		fwd_mask[1])
		else $error("forward late");
endmodule
`default_nettype wire

//--- sim/local_store_model.sv
// Purpose: local store fetch port as seen from the control block
// Assumes: fetch_req stays up until fetch_ready is seen
// Notes: wait_cycles sets the stall before each answer
`timescale 1ns/100ps
`default_nettype none
module local_store_model
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Fetch handshake
	input wire logic fetch_req,
	input wire logic [2:0] wait_cycles,
	output logic fetch_ready
);
	logic [2:0] wait_ff;
	logic [2:0] nxt_wait;

	// Answer once the stall has run out, one block per request
	assign fetch_ready = fetch_req && wait_ff == wait_cycles;
	assign nxt_wait = (fetch_ready || !fetch_req) ? 3'h0 : wait_ff + 3'h1;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			wait_ff <= 3'h0;
		else
			wait_ff <= nxt_wait;
	end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose: self-checking bench for dual_issue_ctl
// Assumes: pairs driven on falling edges, outputs read on rising
// Notes: driver queues notes, watcher pops them as issues appear
`timescale 1ns/100ps
`default_nettype none
`include "issue_ctl_map.svh"
`define CHK(a, b, m) \
	begin \
		checked++; \
		if ((a) !== (b)) \
		begin \
			err_count++; \
			$display("[FAIL] %0t %s", $time, m); \
		end \
	end
module tb
	import issue_ctl_pkg::*;
;
	typedef struct {logic [2:0] p; logic [3:0] el, ol; bit cm;} note_t;
	typedef struct {int cyc; result_t e;} cmt_t;
	typedef struct {fetch_kind_t k; logic [31:0] a;} fnote_t;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	slot_t first_slot, second_slot, fa;
	logic pair_avail, dma_busy, ecc_busy, hint_req, inline_slot_free;
	logic even_busy, odd_busy, odd_rf_readable;
	logic [31:0] hint_addr, inline_addr, ad;
	logic [2:0] wait_cycles;
	logic pair_take, even_issue, odd_issue, dp_element, flush;
	logic fetch_req, fetch_ready, even_rf_readable;
	logic [3:0] even_latency, odd_latency, lat_d;
	fetch_kind_t fetch_kind;
	logic [31:0] fetch_addr;
	logic [5:0] fetch_count;
	result_t even_commit, odd_commit;
	logic [15:0] fwd_ready_mask;
	wire logic [2:0] got = {even_issue, odd_issue, pair_take};
	note_t iss_q[$];
	note_t last;
	cmt_t cm_q[$];
	fnote_t fet_q[$];
	bit lat_due = 0;
	bit quiet = 0;
	logic [1:0] ecv = 2'h0;
	logic [1:0] ocv = 2'h0;
	logic [3:0] fwd_due = 4'h0;
	int err_count = 0, checked = 0, seed = 41, cyc = 0, due = 0;
	int t_e = -1, t_o = -1, dps = 0, n;
	insn_class_t ecls[5] = '{simple_fixed_class, byte_op_class,
		rotate_shift_class, single_float_class, float_integer_class};
	insn_class_t ocls[5] = '{local_store_class, branch_resolve_class,
		shuffle_class, channel_class, branch_hint_class};
	logic [3:0] elat[5] = '{`LAT_SIMPLE, `LAT_BYTE, `LAT_BYTE,
		`LAT_SINGLE, `LAT_FLOATINT};
	logic [3:0] olat[5] = '{`LAT_SINGLE, `LAT_BYTE, `LAT_BYTE,
		`LAT_SINGLE, 4'h0};

	always #10 ref_clk = ~ref_clk;

	dual_issue_ctl dut (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.first_slot(first_slot),
		.second_slot(second_slot),
		.pair_avail(pair_avail),
		.dma_busy(dma_busy),
		.ecc_busy(ecc_busy),
		.even_busy(even_busy),
		.odd_busy(odd_busy),
		.hint_req(hint_req),
		.hint_addr(hint_addr),
		.inline_slot_free(inline_slot_free),
		.inline_addr(inline_addr),
		.fetch_ready(fetch_ready),
		.pair_take(pair_take),
		.even_issue(even_issue),
		.odd_issue(odd_issue),
		.even_latency(even_latency),
		.odd_latency(odd_latency),
		.dp_element(dp_element),
		.flush(flush),
		.fetch_req(fetch_req),
		.fetch_kind(fetch_kind),
		.fetch_addr(fetch_addr),
		.fetch_count(fetch_count),
		.fwd_ready_mask(fwd_ready_mask),
		.even_commit(even_commit),
		.odd_commit(odd_commit),
		.even_rf_readable(even_rf_readable),
		.odd_rf_readable(odd_rf_readable)
	);

	local_store_model ls_model (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.fetch_req(fetch_req),
		.wait_cycles(wait_cycles),
		.fetch_ready(fetch_ready)
	);

////////////////////////////////////////////////////////////////////////////
	// Watcher: pops the oldest note whenever an issue shows, except while quiet
	always @(posedge ref_clk)
	begin
		cyc++;
		if (fwd_due != 4'h0)
			`CHK(fwd_ready_mask[fwd_due - 4'h1], 1'b1, "forward mark")
		fwd_due = lat_due ? last.el : 4'h0;
		if (lat_due && last.el != 4'h0)
			`CHK(even_latency, last.el, "even latency")
		if (lat_due && last.ol != 4'h0)
			`CHK(odd_latency, last.ol, "odd latency")
		lat_due = 0;
		if ((even_issue | odd_issue) === 1'b1 && !quiet)
		begin
			last = iss_q.size() > 0 ? iss_q.pop_front() : '{default: '0};
			lat_due = 1;
			`CHK(got, last.p, "issue pattern")
			if (last.cm)
				cm_q.push_back('{cyc, '{1'b1, first_slot.dest, first_slot.addr}});
		end
		if (cm_q.size() > 0 && cyc == cm_q[0].cyc + 8)
		begin
			`CHK(even_commit, cm_q[0].e, "even commit")
			void'(cm_q.pop_front());
		end
		if (arst_n === 1'b1)
		begin
			`CHK(even_rf_readable, ecv[1], "readable timing")
			`CHK(odd_rf_readable, ocv[1], "odd readable")
			ecv = {ecv[0], even_commit.valid};
			ocv = {ocv[0], odd_commit.valid};
		end
		if (flush === 1'b1)
		begin
			`CHK(due > 0, 1'b1, "unexpected flush")
			due--;
		end
		if ((fetch_req & fetch_ready) === 1'b1 && fet_q.size() > 0)
		begin
			`CHK({fetch_kind, fetch_addr, fetch_count}, {fet_q[0].k, fet_q[0].a, 6'(`FETCH_BLOCK_INSNS)}, "fetch")
			void'(fet_q.pop_front());
		end
		if (quiet)
		begin
			if (even_issue === 1'b1 && t_e < 0)
				t_e = cyc;
			if (odd_issue === 1'b1)
				t_o = cyc;
			if (dp_element === 1'b1)
				dps++;
			if (cyc == t_e + 1)
				lat_d = even_latency;
		end
	end

////////////////////////////////////////////////////////////////////////////
	function automatic slot_t mk(insn_class_t c, int a, logic [6:0] id = 7'h0,
		logic blk = 1'b0);
		mk = '{1'b1, c, 1'b1, blk, blk, id, 5'($random(seed)), 32'(a)};
	endfunction

	task automatic note(input logic [2:0] p, input logic [3:0] el = 4'h0,
		input logic [3:0] ol = 4'h0, input bit cm = 1'b0);
		iss_q.push_back('{p, el, ol, cm});
	endtask

	task automatic idle(input int c);
		pair_avail = 1'b0;
		repeat (c) @(negedge ref_clk);
	endtask

	// Holds the pair until taken or flushed; hold lifts the blockers
	task automatic run(input slot_t f, s, input int hold, output int i);
		first_slot = f;
		second_slot = s;
		pair_avail = 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge ref_clk);
			if ((pair_take | flush) === 1'b1)
				break;
			@(negedge ref_clk);
			if (i == hold)
			begin
				first_slot.dep_ok = 1'b1;
				second_slot.chan_count_zero = 1'b0;
				{dma_busy, ecc_busy, even_busy, odd_busy} = 4'h0;
			end
		end
		@(negedge ref_clk);
		`CHK(i < 40, 1'b1, "pair not taken")
	endtask

	task automatic drain();
		int i;
		for (i = 0; i < 60 && fet_q.size() > 0; i++)
			@(negedge ref_clk);
		`CHK(fet_q.size(), 0, "fetch missing")
	endtask

	task automatic test_done();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

////////////////////////////////////////////////////////////////////////////
	initial
	begin
		first_slot = '0;
		second_slot = '0;
		{pair_avail, dma_busy, ecc_busy, hint_req, inline_slot_free} = '0;
		hint_addr = '0;
		inline_addr = '0;
		wait_cycles = 3'h0;
		{even_busy, odd_busy} = 2'h0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			note(3'h7, elat[k], olat[k], 1);
			run(mk(ecls[k], k * 8), mk(ocls[k], k * 8 + 4), -1, n);
		end
		note(3'h4, `LAT_SIMPLE);
		note(3'h5, `LAT_SIMPLE);
		note(3'h2, 4'h0, `LAT_SINGLE);
		note(3'h3, 4'h0, `LAT_SINGLE);
		note(3'h2, 4'h0, `LAT_SINGLE);
		note(3'h5, `LAT_SIMPLE);
		note(3'h7);
		run(mk(simple_fixed_class, 64), mk(simple_fixed_class, 68), -1, n);
		run(mk(local_store_class, 72), mk(local_store_class, 76), -1, n);
		run(mk(local_store_class, 80), mk(simple_fixed_class, 84), -1, n);
		run(mk(even_pipe_noop, 88), mk(odd_pipe_noop, 92), -1, n);
		fa = mk(simple_fixed_class, 96);
		fa.dep_ok = 1'b0;
		{dma_busy, ecc_busy, even_busy, odd_busy} = 4'hf;
		note(3'h7, `LAT_SIMPLE, `LAT_SINGLE);
		run(fa, mk(local_store_class, 100), 3, n);
		`CHK(n, 4, "issued while not eligible")
		note(3'h4, `LAT_SIMPLE);
		note(3'h3, 4'h0, `LAT_SINGLE);
		fa = mk(channel_class, 108, 7'h11, 1);
		run(mk(simple_fixed_class, 104), fa, 4, n);
		`CHK(n, 5, "blocking channel issued early")
		idle(8);
		wait_cycles = 3'($random(seed));
		note(3'h7, 4'h0, `LAT_SINGLE);
		note(3'h4);
		fet_q.push_back('{fetch_flush, 32'd124});
		due = 1;
		run(mk(even_pipe_noop, 112), mk(channel_class, 116, 7'h22), -1, n);
		run(mk(even_pipe_noop, 120), mk(channel_class, 124, 7'h22), -1, n);
		`CHK(due, 0, "no retry flush")
		idle(6);
		drain();
		fa = '0;
		note(3'h3, 4'h0, `LAT_SINGLE);
		note(3'h7, `LAT_SIMPLE, `LAT_SINGLE);
		note(3'h7, `LAT_SIMPLE, `LAT_SINGLE);
		run(fa, mk(channel_class, 124, 7'h22), -1, n);
		run(mk(simple_fixed_class, 128), mk(channel_class, 132, 7'h30), -1, n);
		run(mk(simple_fixed_class, 136), mk(channel_class, 140, 7'h31), -1, n);
		idle(8);
		note(3'h7, 4'h0, 4'h4);
		due = 1;
		fet_q.push_back('{fetch_flush, 32'd152});
		run(mk(even_pipe_noop, 144), mk(sync_class, 148), -1, n);
		idle(4);
		`CHK(due, 0, "no sync flush")
		drain();
		idle(4);
		quiet = 1;
		run(mk(double_float_class, 160), mk(local_store_class, 164), -1, n);
		idle(2);
		quiet = 0;
		`CHK(t_o - t_e, 8, "double blackout")
		`CHK(dps, 1, "element split")
		`CHK(lat_d, `LAT_DOUBLE, "double latency")
		for (int j = 0; j < 2; j++)
		begin
			wait_cycles = 3'($random(seed));
			ad = 32'($random(seed)) & 32'hffffff80;
			fet_q.push_back('{j == 1 ? fetch_inline : fetch_hint, ad});
			hint_addr = ad;
			inline_addr = ad;
			hint_req = j == 0;
			inline_slot_free = j == 1;
			@(negedge ref_clk);
			{hint_req, inline_slot_free} = 2'h0;
			drain();
			idle(4);
		end
		idle(12);
		`CHK(iss_q.size() + cm_q.size(), 0, "notes left over")
		test_done();
	end

	initial
	begin
		#100000;
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
endmodule
`default_nettype wire
